/* File: verilog/mac_pkg.sv */
// Constants, register indexes and state types shared by the multiply-accumulate block.
// Assumes a single 200 MHz clock and a synchronous active-low reset.
package mac_pkg;

	// ----------------------------------------------------------------
	// Bus and register map (index; byte address is index times four)
	// ----------------------------------------------------------------
	localparam int          ADDR_W      = 10;
	localparam logic [7:0]  IDX_OPA_HI  = 8'he1;
	localparam logic [7:0]  IDX_CFG     = 8'he2;
	localparam logic [7:0]  IDX_WIN_LO  = 8'he4;
	localparam logic [7:0]  IDX_WIN_HI  = 8'he5;
	localparam logic [7:0]  IDX_OPB_HI  = 8'hf7;
	localparam logic [7:0]  IDX_OPA_LO  = 8'h10;
	localparam logic [7:0]  IDX_OPB_LO  = 8'h11;
	localparam logic [7:0]  IDX_CMD     = 8'h12;
	localparam logic [7:0]  IDX_STAT    = 8'h13;
	localparam logic [7:0]  IDX_PROD    = 8'h14;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Field layouts and reset values
	// ----------------------------------------------------------------
	localparam int          CFG_WIN_LSB = 6;
	localparam int          CFG_SGN_B   = 5;
	localparam int          CFG_SGN_A   = 4;
	localparam logic [7:0]  CFG_RESET   = 8'h00;
	localparam logic [7:0]  BYTE_RESET  = 8'h00;
	localparam int          STAT_SIGN   = 0;
	localparam int          STAT_EXCESS = 1;
	localparam int          ACC_W       = 40;
	localparam int          BYTE_W      = 8;

	// ----------------------------------------------------------------
	// Instruction codes written to the command register
	// ----------------------------------------------------------------
	localparam logic [7:0]  OP_PREFIX   = 8'ha5;
	localparam logic [7:0]  OP_PLAIN    = 8'h00;
	localparam logic [7:0]  OP_MAC      = 8'ha4;
	localparam logic [7:0]  OP_CLR      = 8'he4;
	localparam logic [7:0]  OP_LSL      = 8'h23;
	localparam logic [7:0]  OP_ASR      = 8'h03;
	localparam logic [7:0]  OP_BYTE_MUL = 8'ha4;

	// ----------------------------------------------------------------
	// Cycle counts and the commit step
	// ----------------------------------------------------------------
	localparam logic [3:0]  MAC_CYCLES   = 4'h9;
	localparam logic [3:0]  CLR_CYCLES   = 4'h2;
	localparam logic [3:0]  SHIFT_CYCLES = 4'h2;
	localparam logic [3:0]  MUL_CYCLES   = 4'h2;
	localparam logic [3:0]  STEP_COMMIT  = 4'h5;

	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_MAC  = 6'b000010,
		ST_MUL  = 6'b000100,
		ST_CLR  = 6'b001000,
		ST_LSL  = 6'b010000,
		ST_ASR  = 6'b100000
	} mac_state_type;

	typedef struct packed {
		logic                 aw_have;
		logic [7:0]           aw_idx;
		logic                 aw_ok;
		logic                 w_have;
		logic [31:0]          w_data;
		logic                 w_strb0;
		logic                 b_valid;
		logic [1:0]           b_resp;
		logic                 r_valid;
		logic [31:0]          r_data;
		logic [1:0]           r_resp;
		logic [7:0]           opa_hi;
		logic [7:0]           opa_lo;
		logic [7:0]           opb_hi;
		logic [7:0]           opb_lo;
		logic [7:0]           cfg;
		logic [15:0]          byte_prod;
		logic                 sign_flag;
		logic                 excess_flag;
		logic [ACC_W-1:0]     sum;
		logic [31:0]          prod;
		mac_state_type        state;
		logic [3:0]           step;
	} mac_regs_type;

	typedef struct packed {
		logic signed [17:0]   product;
	} mac_mul_regs_type;

endpackage

/* File: verilog/mac_mul_if.sv */
// Operand and product wires between the sequencer and the shared 8-bit multiplier.
// Assumes the multiplier answers one clock after the operands are presented.
interface mac_mul_if;
	logic signed [8:0]  op_x;
	logic signed [8:0]  op_y;
	logic signed [17:0] product;

	modport requester (output op_x, output op_y, input product);
	modport multiplier (input op_x, input op_y, output product);
endinterface

/* File: verilog/mac_mul8.sv */
// The single byte multiplier: two 9-bit signed operands, registered 18-bit product.
// Assumes operands already carry a zero or sign extension chosen by the caller.
module mac_mul8 (
	// Clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// Operands and product
	mac_mul_if.multiplier         mul
);

	mac_pkg::mac_mul_regs_type    st_reg;
	mac_pkg::mac_mul_regs_type    st_next;

	always_comb begin
		st_next = st_reg;
		st_next.product = mul.op_x * mul.op_y;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign mul.product = st_reg.product;

endmodule

/* File: verilog/mac_unit.sv */
// Multiply-accumulate datapath with a 40-bit sum and an AXI4-Lite register port.
// Assumes one bus master; commands arrive as writes to the command register.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
module mac_unit (
	// Clock and reset
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	// Write address channel
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [mac_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]                 s_axi_awprot,
	// Write data channel
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	// Write response channel
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	output logic [1:0]                      s_axi_bresp,
	// Read address channel
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	input  wire logic [mac_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]                 s_axi_arprot,
	// Read data channel
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	// Status
	output logic                            busy
);

	mac_pkg::mac_regs_type  st_reg;
	mac_pkg::mac_regs_type  st_next;
	mac_mul_if              mul ();

	logic                   idle;
	logic [1:0]             win_sel;
	logic [5:0]             win_pos;
	logic [15:0]            win_val;
	logic [7:0]             ar_idx;

	// Top bit of the sum; sign and overflow both watch it
	localparam int          ACC_TOP = mac_pkg::ACC_W - 1;

	// ----------------------------------------------------------------
	// Shared multiplier
	// ----------------------------------------------------------------
	mac_mul8 u_mul (
		.aclk    (aclk),
		.aresetn (aresetn),
		.mul     (mul.multiplier)
	);

	assign idle    = (st_reg.state == mac_pkg::ST_IDLE);
	assign busy    = !idle;
	assign win_sel = st_reg.cfg[mac_pkg::CFG_WIN_LSB +: 2];
	assign win_pos = {1'b0, win_sel, 3'b000};
	assign win_val = st_reg.sum[win_pos +: 16];
	assign ar_idx  = s_axi_araddr[9:2];

	// Operand feed: low bytes zero-extended, high bytes sign-extended for the
	// wide product; the byte multiply instead obeys the two select bits.
	// Partial products go low by low, high by low, low by high, high by high;
	// each product comes back one clock after its operands are fed.
	always_comb begin
		mul.op_x = {1'b0, st_reg.opa_lo};
		mul.op_y = {1'b0, st_reg.opb_lo};
		if (st_reg.state == mac_pkg::ST_MAC) begin
			unique case (st_reg.step)
				4'h1: begin
					mul.op_x = {st_reg.opa_hi[7], st_reg.opa_hi};
				end
				4'h2: begin
					mul.op_y = {st_reg.opb_hi[7], st_reg.opb_hi};
				end
				4'h3: begin
					mul.op_x = {st_reg.opa_hi[7], st_reg.opa_hi};
					mul.op_y = {st_reg.opb_hi[7], st_reg.opb_hi};
				end
				default: begin
					mul.op_x = {1'b0, st_reg.opa_lo};
				end
			endcase
		end else if (st_reg.state == mac_pkg::ST_MUL) begin
			mul.op_x = {st_reg.cfg[mac_pkg::CFG_SGN_A] & st_reg.opa_lo[7], st_reg.opa_lo};
			mul.op_y = {st_reg.cfg[mac_pkg::CFG_SGN_B] & st_reg.opb_lo[7], st_reg.opb_lo};
		end
	end

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic [31:0]            pp_ext;
		logic [ACC_TOP:0]       prod_ext;
		logic [ACC_TOP:0]       sum_add;
		logic [5:0]             wr_pos;
		pp_ext   = {{14{mul.product[17]}}, mul.product};
		prod_ext = {{8{st_reg.prod[31]}}, st_reg.prod};
		sum_add  = st_reg.sum + prod_ext;
		wr_pos   = win_pos;
		st_next  = st_reg;

		// Write address and data are taken independently, in either order
		if (s_axi_awvalid && !st_reg.aw_have) begin
			st_next.aw_have = 1'b1;
			st_next.aw_idx  = s_axi_awaddr[9:2];
		end
		if (s_axi_wvalid && !st_reg.w_have) begin
			st_next.w_have  = 1'b1;
			st_next.w_data  = s_axi_wdata;
			st_next.w_strb0 = s_axi_wstrb[0];
		end
		if (st_reg.b_valid && s_axi_bready) begin
			st_next.b_valid = 1'b0;
		end
		if (st_reg.r_valid && s_axi_rready) begin
			st_next.r_valid = 1'b0;
		end

		// Sequencer
		st_next.step = st_reg.step + 4'h1;
		unique case (st_reg.state)
			mac_pkg::ST_IDLE: begin
				st_next.step = 4'h0;
			end
			// Step n folds in the partial product fed at step n-1; the sum
			// takes the finished product once, at the commit step
			mac_pkg::ST_MAC: begin
				unique case (st_reg.step)
					4'h1: st_next.prod = pp_ext;
					4'h2: st_next.prod = st_reg.prod + (pp_ext << mac_pkg::BYTE_W);
					4'h3: st_next.prod = st_reg.prod + (pp_ext << mac_pkg::BYTE_W);
					4'h4: st_next.prod = st_reg.prod + (pp_ext << (2 * mac_pkg::BYTE_W));
					default: st_next.prod = st_reg.prod;
				endcase
				if (st_reg.step == mac_pkg::STEP_COMMIT) begin
					st_next.sum       = sum_add;
					st_next.sign_flag = sum_add[ACC_TOP];
					if ((st_reg.sum[ACC_TOP] == prod_ext[ACC_TOP]) &&
						(sum_add[ACC_TOP] != st_reg.sum[ACC_TOP])) begin
						st_next.excess_flag = 1'b1;
					end
				end
				if (st_reg.step == mac_pkg::MAC_CYCLES - 4'h1) begin
					st_next.state = mac_pkg::ST_IDLE;
				end
			end
			mac_pkg::ST_MUL: begin
				if (st_reg.step == mac_pkg::MUL_CYCLES - 4'h1) begin
					st_next.byte_prod = mul.product[15:0];
					st_next.state     = mac_pkg::ST_IDLE;
				end
			end
			mac_pkg::ST_CLR: begin
				st_next.sum = '0;
				if (st_reg.step == mac_pkg::CLR_CYCLES - 4'h1) begin
					st_next.state = mac_pkg::ST_IDLE;
				end
			end
			mac_pkg::ST_LSL: begin
				if (st_reg.step == 4'h0) begin
					st_next.sum = {st_reg.sum[ACC_TOP-1:0], 1'b0};
				end
				if (st_reg.step == mac_pkg::SHIFT_CYCLES - 4'h1) begin
					st_next.state = mac_pkg::ST_IDLE;
				end
			end
			mac_pkg::ST_ASR: begin
				if (st_reg.step == 4'h0) begin
					st_next.sum = {st_reg.sum[ACC_TOP], st_reg.sum[ACC_TOP:1]};
				end
				if (st_reg.step == mac_pkg::SHIFT_CYCLES - 4'h1) begin
					st_next.state = mac_pkg::ST_IDLE;
				end
			end
			default: begin
				st_next.state = mac_pkg::ST_IDLE;
			end
		endcase

		// Register writes wait for the sequencer, which stalls the bus master
		if (st_reg.aw_have && st_reg.w_have && !st_reg.b_valid && idle) begin
			st_next.aw_have = 1'b0;
			st_next.w_have  = 1'b0;
			st_next.b_valid = 1'b1;
			st_next.b_resp  = mac_pkg::RESP_OKAY;
			st_next.step    = 4'h0;
			unique case (st_reg.aw_idx)
				mac_pkg::IDX_OPA_HI: if (st_reg.w_strb0) st_next.opa_hi = st_reg.w_data[7:0];
				mac_pkg::IDX_OPB_HI: if (st_reg.w_strb0) st_next.opb_hi = st_reg.w_data[7:0];
				mac_pkg::IDX_OPA_LO: if (st_reg.w_strb0) st_next.opa_lo = st_reg.w_data[7:0];
				mac_pkg::IDX_OPB_LO: if (st_reg.w_strb0) st_next.opb_lo = st_reg.w_data[7:0];
				mac_pkg::IDX_CFG:    if (st_reg.w_strb0) st_next.cfg = st_reg.w_data[7:0];
				mac_pkg::IDX_WIN_LO: begin
					if (st_reg.w_strb0) st_next.sum[wr_pos +: 8] = st_reg.w_data[7:0];
				end
				mac_pkg::IDX_WIN_HI: begin
					wr_pos = win_pos + 6'h08;
					if (st_reg.w_strb0) st_next.sum[wr_pos +: 8] = st_reg.w_data[7:0];
				end
				mac_pkg::IDX_STAT: begin
					if (st_reg.w_strb0 && st_reg.w_data[mac_pkg::STAT_EXCESS]) begin
						st_next.excess_flag = 1'b0;
					end
				end
				mac_pkg::IDX_CMD: begin
					if (st_reg.w_strb0 && st_reg.w_data[15:8] == mac_pkg::OP_PREFIX) begin
						unique case (st_reg.w_data[7:0])
							mac_pkg::OP_MAC: st_next.state = mac_pkg::ST_MAC;
							mac_pkg::OP_CLR: st_next.state = mac_pkg::ST_CLR;
							mac_pkg::OP_LSL: st_next.state = mac_pkg::ST_LSL;
							mac_pkg::OP_ASR: st_next.state = mac_pkg::ST_ASR;
							default: st_next.state = mac_pkg::ST_IDLE;
						endcase
					end else if (st_reg.w_strb0 && st_reg.w_data[15:8] == mac_pkg::OP_PLAIN &&
						st_reg.w_data[7:0] == mac_pkg::OP_BYTE_MUL) begin
						st_next.state = mac_pkg::ST_MUL;
					end
				end
				default: st_next.b_resp = mac_pkg::RESP_SLVERR;
			endcase
		end

		// Reads are held off while an operation runs so no partial sum is seen
		if (s_axi_arvalid && s_axi_arready) begin
			st_next.r_valid = 1'b1;
			st_next.r_resp  = mac_pkg::RESP_OKAY;
			st_next.r_data  = '0;
			unique case (ar_idx)
				mac_pkg::IDX_OPA_HI: st_next.r_data[7:0] = st_reg.opa_hi;
				mac_pkg::IDX_OPB_HI: st_next.r_data[7:0] = st_reg.opb_hi;
				mac_pkg::IDX_OPA_LO: st_next.r_data[7:0] = st_reg.opa_lo;
				mac_pkg::IDX_OPB_LO: st_next.r_data[7:0] = st_reg.opb_lo;
				mac_pkg::IDX_CFG:    st_next.r_data[7:0] = st_reg.cfg;
				mac_pkg::IDX_WIN_LO: st_next.r_data[7:0] = win_val[7:0];
				mac_pkg::IDX_WIN_HI: st_next.r_data[7:0] = win_val[15:8];
				mac_pkg::IDX_PROD:   st_next.r_data[15:0] = st_reg.byte_prod;
				mac_pkg::IDX_CMD:    st_next.r_data = '0;
				mac_pkg::IDX_STAT: begin
					st_next.r_data[mac_pkg::STAT_SIGN]   = st_reg.sign_flag;
					st_next.r_data[mac_pkg::STAT_EXCESS] = st_reg.excess_flag;
				end
				default: st_next.r_resp = mac_pkg::RESP_SLVERR;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// Clearing the whole struct also empties the sum and both flags
			st_reg        <= '0;
			st_reg.state  <= mac_pkg::ST_IDLE;
			st_reg.cfg    <= mac_pkg::CFG_RESET;
			st_reg.opa_hi <= mac_pkg::BYTE_RESET;
			st_reg.opb_hi <= mac_pkg::BYTE_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// Bus outputs
	// ----------------------------------------------------------------
	// A held address or data word blocks the next one until it has executed,
	// which is how a running operation stalls the host
	assign s_axi_awready = !st_reg.aw_have;
	assign s_axi_wready  = !st_reg.w_have;
	assign s_axi_bvalid  = st_reg.b_valid;
	assign s_axi_bresp   = st_reg.b_resp;
	assign s_axi_arready = idle && !st_reg.r_valid;
	assign s_axi_rvalid  = st_reg.r_valid;
	assign s_axi_rdata   = st_reg.r_data;
	assign s_axi_rresp   = st_reg.r_resp;

endmodule

/* File: tb/mac_props.sv */
// Concurrent checks on the register port and the busy timing of mac_unit.
// Assumes it is bound to mac_unit and sees nothing but its ports.
module mac_props (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Write side
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	// Read side
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	// Status
	input wire logic        busy
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------
	// Last write data word, to any register; a new word cannot be taken before the held one runs
	// ------------------------------------------------
	logic [15:0] cmd_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			cmd_reg <= 16'h0000;
		else if (s_axi_wvalid && s_axi_wready)
			cmd_reg <= s_axi_wdata[15:0];
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_mac_nine_cycles: assert property ($rose(busy) && cmd_reg == 16'ha5a4 |-> busy [*8] ##1 busy ##1 !busy)
		else $error("multiply-accumulate busy length wrong");
	a_short_op_cycles: assert property ($rose(busy) && cmd_reg != 16'ha5a4 |-> busy ##1 busy ##1 !busy)
		else $error("short operation busy length wrong");
	a_read_stall_busy: assert property (busy |-> !s_axi_arready)
		else $error("read accepted while busy");
	a_read_one_pending: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted with answer pending");
	a_read_answer_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_data_held: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read answer dropped or changed");
	a_write_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped or changed");
	a_write_answer_soon: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		&& !busy && !s_axi_bvalid |-> ##[1:2] s_axi_bvalid) else $error("write response late");
endmodule

bind mac_unit mac_props props (
	.aclk(aclk), .aresetn(aresetn), .busy(busy),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp)
);

/* File: tb/mac_host.sv */
// Host core model: issues register reads and writes as an AXI4-Lite master.
// Assumes one clock; the bench calls its tasks one at a time.
module mac_host (
	// Clock
	input wire logic        aclk,
	// Requests
	output logic            s_axi_awvalid = 1'b0,
	output logic [9:0]      s_axi_awaddr  = 10'h000,
	output logic            s_axi_wvalid  = 1'b0,
	output logic [31:0]     s_axi_wdata   = 32'h00000000,
	output logic            s_axi_bready  = 1'b0,
	output logic            s_axi_arvalid = 1'b0,
	output logic [9:0]      s_axi_araddr  = 10'h000,
	output logic            s_axi_rready  = 1'b0,
	// Answers
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------
	// Bus cycles; the answer ready stands from the request until the answer is taken
	// ------------------------------------------------
	task automatic wr(input logic [9:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr  <= a;
		s_axi_wvalid  <= 1'b1;
		s_axi_wdata   <= d;
		s_axi_bready  <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr  <= a;
		s_axi_rready  <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask
endmodule

/* File: tb/mac_unit_bench.sv */
// Self-checking bench for mac_unit: drives it through the host model.
// Assumes a 200 MHz clock and a synchronous active-low reset.
module mac_unit_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, busy;
	logic [9:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rdat;
	logic [1:0] bresp, rresp, resp;
	logic [39:0] m;
	logic [1:0] sgn = 2'b00;
	int miscompares = 0;
	int tests_run = 0;
	int run_len = 0;
	int last_len = 0;
	int cycles = 0;

	mac_unit DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .busy(busy));
	mac_host host (.aclk(aclk), .s_axi_awvalid(awvalid), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
		.s_axi_wdata(wdata), .s_axi_bready(bready), .s_axi_arvalid(arvalid), .s_axi_araddr(araddr),
		.s_axi_rready(rready), .s_axi_awready(awready), .s_axi_wready(wready), .s_axi_bvalid(bvalid),
		.s_axi_bresp(bresp), .s_axi_arready(arready), .s_axi_rvalid(rvalid), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp));

	// ------------------------------------------------
	// Clock, busy length monitor and hang guard
	// ------------------------------------------------
	initial begin
		forever #2.5 aclk = ~aclk;
	end

	always @(negedge aclk) begin
		cycles++;
		if (busy === 1'b1) run_len++;
		else if (run_len != 0) begin
			last_len = run_len;
			run_len = 0;
		end
		if (cycles == 20000) begin
			miscompares++;
			tally_and_finish();
		end
	end

	task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wreg(input logic [7:0] idx, input logic [15:0] d);
		host.wr({idx, 2'b00}, {16'h0000, d}, resp);
		chk("write response", 40'(mac_pkg::RESP_OKAY), 40'(resp));
	endtask

	task automatic rreg(input logic [7:0] idx, output logic [15:0] d);
		host.rd({idx, 2'b00}, rdat, resp);
		d = rdat[15:0];
		chk("read response", 40'(mac_pkg::RESP_OKAY), 40'(resp));
	endtask

	function automatic logic [39:0] prod(input logic [15:0] a, input logic [15:0] b);
		logic signed [31:0] p;
		p = $signed(a) * $signed(b);
		return {{8{p[31]}}, p};
	endfunction

	function automatic logic [15:0] bprod(input logic [7:0] a, input logic [7:0] b, input logic [1:0] s);
		logic signed [8:0] x, y;
		logic signed [17:0] p;
		x = {s[0] & a[7], a};
		y = {s[1] & b[7], b};
		p = x * y;
		return p[15:0];
	endfunction

	// Runs a command and checks how long busy stood
	task automatic op(input logic [15:0] cmd, input int len);
		wreg(mac_pkg::IDX_CMD, cmd);
		while (busy !== 1'b0 || run_len != 0) @(posedge aclk);
		chk("busy cycles", 40'(len), 40'(last_len));
	endtask

	task automatic put_win(input logic [1:0] s, input logic [15:0] v);
		wreg(mac_pkg::IDX_CFG, {8'h00, s, sgn, 4'h0});
		wreg(mac_pkg::IDX_WIN_LO, {8'h00, v[7:0]});
		wreg(mac_pkg::IDX_WIN_HI, {8'h00, v[15:8]});
	endtask

	task automatic chk_sum(input logic [39:0] exp);
		logic [15:0] lo, hi;
		for (int s = 0; s < 4; s++) begin
			wreg(mac_pkg::IDX_CFG, {8'h00, 2'(s), sgn, 4'h0});
			rreg(mac_pkg::IDX_WIN_LO, lo);
			rreg(mac_pkg::IDX_WIN_HI, hi);
			chk("sum window", 40'(exp[s*8 +: 16]), 40'({hi[7:0], lo[7:0]}));
		end
	endtask

	task automatic chk_stat(input logic [1:0] exp);
		logic [15:0] d;
		rreg(mac_pkg::IDX_STAT, d);
		chk("status flags", 40'(exp), 40'(d[1:0]));
	endtask

	// ------------------------------------------------
	// Scenarios
	// ------------------------------------------------
	task automatic t_reset;
		logic [15:0] d;
		rreg(mac_pkg::IDX_CFG, d);
		chk("config reset", 40'(mac_pkg::CFG_RESET), 40'(d[7:0]));
		chk_stat(2'b00);
		host.rd(10'h080, rdat, resp);
		chk("unmapped read", 40'(mac_pkg::RESP_SLVERR), 40'(resp));
		host.wr(10'h080, 32'h00000000, resp);
		chk("unmapped write", 40'(mac_pkg::RESP_SLVERR), 40'(resp));
		chk_sum(40'h0);
	endtask

	task automatic t_mac;
		logic [15:0] d;
		op(16'ha5e4, 2);
		wreg(mac_pkg::IDX_OPA_HI, 16'h00ff);
		wreg(mac_pkg::IDX_OPA_LO, 16'h00fd);
		wreg(mac_pkg::IDX_OPB_HI, 16'h007f);
		wreg(mac_pkg::IDX_OPB_LO, 16'h00ff);
		for (int k = 0; k < 2; k++) begin
			sgn = 2'(k * 3);
			wreg(mac_pkg::IDX_CFG, {8'h00, 2'b00, sgn, 4'h0});
			op(16'ha5a4, 9);
		end
		m = prod(16'hfffd, 16'h7fff) + prod(16'hfffd, 16'h7fff);
		chk_sum(m);
		rreg(mac_pkg::IDX_OPA_HI, d);
		chk("operand one high", 40'h0000ff, 40'(d));
		rreg(mac_pkg::IDX_OPB_LO, d);
		chk("operand two low", 40'h0000ff, 40'(d));
		chk_stat(2'b01);
	endtask

	task automatic t_shift;
		for (int k = 0; k < 3; k++) begin
			op(k == 0 ? 16'ha523 : 16'ha503, 2);
			m = (k == 0) ? {m[38:0], 1'b0} : {m[39], m[39:1]};
			chk_sum(m);
		end
	endtask

	task automatic t_excess;
		sgn = 2'b00;
		op(16'ha5e4, 2);
		put_win(2'd2, 16'hffff);
		put_win(2'd3, 16'h7fff);
		put_win(2'd0, 16'hffff);
		wreg(mac_pkg::IDX_OPA_HI, 16'h0000);
		wreg(mac_pkg::IDX_OPB_HI, 16'h0000);
		wreg(mac_pkg::IDX_OPA_LO, 16'h0001);
		wreg(mac_pkg::IDX_OPB_LO, 16'h0001);
		op(16'ha5a4, 9);
		chk_sum(40'h8000000000);
		chk_stat(2'b11);
		op(16'ha5e4, 2);
		op(16'ha5a4, 9);
		chk_stat(2'b10);
		wreg(mac_pkg::IDX_STAT, 16'h0002);
		chk_stat(2'b00);
	endtask

	task automatic t_byte;
		logic [15:0] d;
		wreg(mac_pkg::IDX_OPA_LO, 16'h00fe);
		wreg(mac_pkg::IDX_OPB_LO, 16'h00fd);
		for (int k = 0; k < 4; k++) begin
			sgn = 2'(k);
			wreg(mac_pkg::IDX_CFG, {8'h00, 2'b00, sgn, 4'h0});
			op(16'h00a4, 2);
			rreg(mac_pkg::IDX_PROD, d);
			chk("byte product", 40'(bprod(8'hfe, 8'hfd, sgn)), 40'(d));
		end
	endtask

	task automatic tally_and_finish;
		if (miscompares == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_mac();
		t_shift();
		t_excess();
		t_byte();
		tally_and_finish();
	end
endmodule
